// *** design/sar_link_pkg.sv ***
package sar_link_pkg;

	localparam int CLK_MHZ = 50;
	localparam int RESULT_W = 16;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 5;
	localparam int CFG_W = 8;
	localparam int TIMER_W = 8;
	// reference mode field position inside the frame word
	localparam int REF_POS = FRAME_BITS - CFG_W;

	// longest conversion time, and a least wait derived from it
	localparam int CONV_TIME_NS = 1500;
	localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	// one trial bit per step; all steps fit inside the longest time
	localparam int SAR_STEP_CYC = (CONV_TIME_NS * CLK_MHZ / 1000) / (RESULT_W + 1);
	localparam int ACQ_TIME_NS = 500;
	localparam int ACQ_CYC = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int MIN_RATE_HZ = 10;
	localparam int MAX_GAP_CYC = CLK_MHZ * 1000000 / MIN_RATE_HZ;
	// host serial clock: half period in system clocks
	localparam int SCLK_HALF_CYC = 4;

	typedef enum logic [1:0] {
		REF_INT_BUF = 2'h0,
		REF_EXT_BUF = 2'h1,
		REF_BG_ONLY = 2'h2,
		REF_ALL_OFF = 2'h3
	} ref_mode_type;

	localparam ref_mode_type REF_RESET = REF_INT_BUF;

	typedef enum logic [1:0] {
		CV_IDLE = 2'h1,
		CV_RUN = 2'h2
	} conv_state_type;

	typedef enum logic [5:0] {
		H_IDLE = 6'h01,
		H_CONV = 6'h02,
		H_HIGH = 6'h04,
		H_LOW = 6'h08,
		H_ACQ = 6'h10,
		H_SPARE = 6'h20
	} host_state_type;

endpackage

// *** design/sar_link_if.sv ***
`timescale 1ns/1ps
// serial link between the converter and its host
interface sar_link_if;
	logic convert_start_pin;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe;

	modport device (
		input convert_start_pin,
		input sclk,
		input din,
		output dout,
		output dout_oe
	);

	modport host (
		output convert_start_pin,
		output sclk,
		output din,
		input dout,
		input dout_oe
	);
endinterface

// *** design/sar_adc_device.sv ***
`timescale 1ns/1ps
module sar_adc_device (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	sar_link_if.device link,
	input wire logic [sar_link_pkg::RESULT_W-1:0] sample_in,
	output logic conv_busy,
	output logic [sar_link_pkg::RESULT_W-1:0] conv_result,
	output sar_link_pkg::ref_mode_type ref_mode,
	output logic bandgap_on,
	output logic ref_buffer_on
);
	import sar_link_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// internal clock domain: start detection and conversion

	logic cnv_s1_reg;
	logic cnv_s2_reg;
	logic cnv_s3_reg;
	logic start_pulse;
	conv_state_type conv_state_reg, conv_state_next;
	logic [RESULT_W-1:0] samp_reg, samp_next;
	logic [RESULT_W-1:0] acc_reg, acc_next;
	logic [RESULT_W-1:0] mask_reg, mask_next;
	logic [RESULT_W-1:0] result_reg, result_next;
	logic [TIMER_W-1:0] step_reg, step_next;
	logic [RESULT_W-1:0] trial;

	// convert-start pin synchroniser plus edge history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnv_s1_reg <= 1'b0;
			cnv_s2_reg <= 1'b0;
			cnv_s3_reg <= 1'b0;
		end else if (ce) begin
			cnv_s1_reg <= link.convert_start_pin;
			cnv_s2_reg <= cnv_s1_reg;
			cnv_s3_reg <= cnv_s2_reg;
		end
	end

	assign start_pulse = cnv_s2_reg & ~cnv_s3_reg; // rising edge only
	assign trial = acc_reg | mask_reg;

	// successive approximation, one trial bit per step
	always_comb begin
		conv_state_next = conv_state_reg;
		samp_next = samp_reg;
		acc_next = acc_reg;
		mask_next = mask_reg;
		result_next = result_reg;
		step_next = step_reg;
		case (conv_state_reg)
			CV_IDLE: begin
				if (start_pulse) begin // sample held, new conversion
					samp_next = sample_in;
					acc_next = '0;
					mask_next = {1'b1, {(RESULT_W-1){1'b0}}};
					step_next = '0;
					conv_state_next = CV_RUN;
				end
			end
			CV_RUN: begin
				if (step_reg == TIMER_W'(SAR_STEP_CYC - 1)) begin // internal clock
					step_next = '0;
					if (samp_reg >= trial) begin
						acc_next = trial;
					end
					mask_next = mask_reg >> 1;
					if (mask_reg[0]) begin // sixteenth bit decided
						result_next = (samp_reg >= trial) ? trial : acc_reg;
						conv_state_next = CV_IDLE;
					end
				end else begin
					step_next = step_reg + TIMER_W'(1);
				end
			end
			default: begin
				conv_state_next = CV_IDLE;
			end
		endcase
	end

	// conversion registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_state_reg <= CV_IDLE;
			samp_reg <= '0;
			acc_reg <= '0;
			mask_reg <= '0;
			result_reg <= '0;
			step_reg <= '0;
		end else if (ce) begin
			conv_state_reg <= conv_state_next;
			samp_reg <= samp_next;
			acc_reg <= acc_next;
			mask_reg <= mask_next;
			result_reg <= result_next;
			step_reg <= step_next;
		end
	end

	assign conv_busy = (conv_state_reg == CV_RUN);
	assign conv_result = result_reg;

	////////////////////////////////////////////////////////////////////////////
	// link domain: select, shift out, shift in

	logic en_reg;
	logic [RESULT_W-1:0] tx_reg;
	logic [CNT_W-1:0] fall_cnt_reg, fall_cnt_next;
	logic [CNT_W-1:0] rise_cnt_reg, rise_cnt_next;
	logic [FRAME_BITS-1:0] rx_reg, rx_next;
	logic [CFG_W-1:0] cfg_reg, cfg_next;
	logic cfg_tgl_reg, cfg_tgl_next;
	logic [RESULT_W-1:0] tx_shifted;
	logic frame_live;

	// falling convert-start: latch clock level and the finished result;
	// the result is stable here because the host waits out the conversion
	always_ff @(negedge link.convert_start_pin or posedge rst) begin
		if (rst) begin
			en_reg <= 1'b0;
			tx_reg <= '0;
		end else begin
			en_reg <= link.sclk; // enabled only if clock was high
			tx_reg <= result_reg;
		end
	end

	assign frame_live = ~link.convert_start_pin & en_reg;

	// bit counters stop at the frame length
	always_comb begin
		fall_cnt_next = fall_cnt_reg;
		rise_cnt_next = rise_cnt_reg;
		if (en_reg && fall_cnt_reg != CNT_W'(FRAME_BITS)) begin
			fall_cnt_next = fall_cnt_reg + CNT_W'(1);
		end
		if (en_reg && rise_cnt_reg != CNT_W'(FRAME_BITS)) begin
			rise_cnt_next = rise_cnt_reg + CNT_W'(1);
		end
	end

	// output advances on falling clock, held clear while deselected
	always_ff @(negedge link.sclk or posedge rst or posedge link.convert_start_pin) begin
		if (rst) begin
			fall_cnt_reg <= '0;
		end else if (link.convert_start_pin) begin
			fall_cnt_reg <= '0; // deselected edges do nothing
		end else begin
			fall_cnt_reg <= fall_cnt_next; // next bit on falling edge
		end
	end

	// input bit count on rising clock
	always_ff @(posedge link.sclk or posedge rst or posedge link.convert_start_pin) begin
		if (rst) begin
			rise_cnt_reg <= '0;
		end else if (link.convert_start_pin) begin
			rise_cnt_reg <= '0;
		end else begin
			rise_cnt_reg <= rise_cnt_next;
		end
	end

	// shift in configuration, commit after a full frame
	always_comb begin
		rx_next = rx_reg;
		cfg_next = cfg_reg;
		cfg_tgl_next = cfg_tgl_reg;
		if (frame_live && rise_cnt_reg != CNT_W'(FRAME_BITS)) begin
			rx_next = {rx_reg[FRAME_BITS-2:0], link.din};
			if (rise_cnt_reg == CNT_W'(FRAME_BITS - 1)) begin
				cfg_next = rx_next[FRAME_BITS-1 -: CFG_W]; // config register
				cfg_tgl_next = ~cfg_tgl_reg;
			end
		end
	end

	// configuration shift registers
	always_ff @(posedge link.sclk or posedge rst) begin
		if (rst) begin
			rx_reg <= '0;
			cfg_reg <= '0;
			cfg_tgl_reg <= 1'b0;
		end else begin
			rx_reg <= rx_next;
			cfg_reg <= cfg_next;
			cfg_tgl_reg <= cfg_tgl_next;
		end
	end

	// top bit shows before any clock edge, then one per fall
	assign tx_shifted = tx_reg << fall_cnt_reg;
	assign link.dout = tx_shifted[RESULT_W-1];
	assign link.dout_oe = frame_live & (fall_cnt_reg != CNT_W'(FRAME_BITS));

	////////////////////////////////////////////////////////////////////////////
	// configuration crossing and reference control

	logic tg_s1_reg;
	logic tg_s2_reg;
	logic tg_s3_reg;
	ref_mode_type mode_reg, mode_next;
	logic bg_reg, bg_next;
	logic buf_reg, buf_next;

	// toggle synchroniser; the word is stable when the toggle arrives
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tg_s1_reg <= 1'b0;
			tg_s2_reg <= 1'b0;
			tg_s3_reg <= 1'b0;
		end else if (ce) begin
			tg_s1_reg <= cfg_tgl_reg;
			tg_s2_reg <= tg_s1_reg;
			tg_s3_reg <= tg_s2_reg;
		end
	end

	// reference mode decode
	always_comb begin
		mode_next = mode_reg;
		if (tg_s2_reg ^ tg_s3_reg) begin
			mode_next = ref_mode_type'(cfg_reg[REF_POS - (FRAME_BITS - CFG_W) +: $bits(ref_mode_type)]);
		end
		case (mode_next)
			REF_INT_BUF: begin
				bg_next = 1'b1; // bandgap feeds buffer
				buf_next = 1'b1;
			end
			REF_EXT_BUF: begin
				bg_next = 1'b0; // external source through buffer
				buf_next = 1'b1;
			end
			REF_BG_ONLY: begin
				bg_next = 1'b1; // buffer off, its pin floats
				buf_next = 1'b0;
			end
			default: begin
				bg_next = 1'b0; // both shut down
				buf_next = 1'b0;
			end
		endcase
	end

	// reference control registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= REF_RESET;
			bg_reg <= 1'b1;
			buf_reg <= 1'b1;
		end else if (ce) begin
			mode_reg <= mode_next;
			bg_reg <= bg_next;
			buf_reg <= buf_next;
		end
	end

	assign ref_mode = mode_reg;
	assign bandgap_on = bg_reg;
	assign ref_buffer_on = buf_reg;

endmodule

// *** design/sar_adc_host.sv ***
`timescale 1ns/1ps
module sar_adc_host #(
	parameter int MAX_GAP = sar_link_pkg::MAX_GAP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	sar_link_if.host link,
	input wire logic start,
	input wire logic [sar_link_pkg::CFG_W-1:0] cfg_in,
	output logic ready,
	output logic [sar_link_pkg::RESULT_W-1:0] data_out,
	output logic data_valid
);
	import sar_link_pkg::*;

	host_state_type state_reg, state_next;
	logic [TIMER_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] bit_reg, bit_next;
	logic sclk_reg, sclk_next;
	logic convert_start_pin_reg, convert_start_pin_next;
	logic din_reg, din_next;
	logic [FRAME_BITS-1:0] tx_reg, tx_next;
	logic [RESULT_W-1:0] rx_reg, rx_next;
	logic [RESULT_W-1:0] data_reg, data_next;
	logic valid_reg, valid_next;
	logic [31:0] gap_reg, gap_next;
	logic gap_due;
	logic dout_s1_reg;
	logic dout_s2_reg;

	////////////////////////////////////////////////////////////////////////////
	// serial data input synchroniser

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout_s1_reg <= 1'b0;
			dout_s2_reg <= 1'b0;
		end else if (ce) begin
			dout_s1_reg <= link.dout;
			dout_s2_reg <= dout_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame sequencer

	assign gap_due = (gap_reg == 32'(MAX_GAP - 1)); // forced minimum rate

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		bit_next = bit_reg;
		sclk_next = sclk_reg;
		convert_start_pin_next = convert_start_pin_reg;
		din_next = din_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		data_next = data_reg;
		valid_next = 1'b0;
		gap_next = gap_due ? gap_reg : gap_reg + 32'h1;
		case (state_reg)
			H_IDLE: begin
				sclk_next = 1'b1;
				if (start || gap_due) begin
					convert_start_pin_next = 1'b1; // rising edge starts conversion
					cnt_next = '0;
					gap_next = '0;
					tx_next = {cfg_in, {(FRAME_BITS-CFG_W){1'b0}}};
					state_next = H_CONV;
				end
			end
			H_CONV: begin
				if (cnt_reg == TIMER_W'(CONV_CYC - 1)) begin // wait out conversion
					convert_start_pin_next = 1'b0; // falls with clock held high
					cnt_next = '0;
					bit_next = '0;
					state_next = H_HIGH;
				end else begin
					cnt_next = cnt_reg + TIMER_W'(1);
				end
			end
			H_HIGH: begin
				if (cnt_reg == TIMER_W'(SCLK_HALF_CYC - 1)) begin
					rx_next = {rx_reg[RESULT_W-2:0], dout_s2_reg}; // sample before fall
					bit_next = bit_reg + CNT_W'(1);
					sclk_next = 1'b0;
					din_next = tx_reg[FRAME_BITS-1]; // stable at next rise
					tx_next = tx_reg << 1;
					cnt_next = '0;
					state_next = H_LOW;
				end else begin
					cnt_next = cnt_reg + TIMER_W'(1);
				end
			end
			H_LOW: begin
				if (cnt_reg == TIMER_W'(SCLK_HALF_CYC - 1)) begin
					sclk_next = 1'b1;
					cnt_next = '0;
					if (bit_reg == CNT_W'(FRAME_BITS)) begin
						data_next = rx_reg;
						valid_next = 1'b1;
						state_next = H_ACQ;
					end else begin
						state_next = H_HIGH;
					end
				end else begin
					cnt_next = cnt_reg + TIMER_W'(1);
				end
			end
			H_ACQ: begin
				if (cnt_reg == TIMER_W'(ACQ_CYC - 1)) begin // acquisition interval
					cnt_next = '0;
					state_next = H_IDLE;
				end else begin
					cnt_next = cnt_reg + TIMER_W'(1);
				end
			end
			default: begin
				state_next = H_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= H_IDLE;
			cnt_reg <= '0;
			bit_reg <= '0;
			sclk_reg <= 1'b1;
			convert_start_pin_reg <= 1'b0;
			din_reg <= 1'b0;
			tx_reg <= '0;
			rx_reg <= '0;
			data_reg <= '0;
			valid_reg <= 1'b0;
			gap_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			sclk_reg <= sclk_next;
			convert_start_pin_reg <= convert_start_pin_next;
			din_reg <= din_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			data_reg <= data_next;
			valid_reg <= valid_next;
			gap_reg <= gap_next;
		end
	end

	assign link.sclk = sclk_reg;
	assign link.convert_start_pin = convert_start_pin_reg;
	assign link.din = din_reg;
	assign ready = (state_reg == H_IDLE);
	assign data_out = data_reg;
	assign data_valid = valid_reg;

endmodule

// *** test/sar_link_checker.sv ***
`timescale 1ns/1ps
module sar_link_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic convert_start_pin,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	logic convert_start_pin_d_reg;
	logic sclk_d_reg;
	logic [4:0] fall_reg;
	logic [7:0] high_reg;
	logic [7:0] gap_reg;
	logic [4:0] falls;
	////////////////////////////////////////////////////////////////
	// falls per frame, high time of start, idle time of the output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			convert_start_pin_d_reg <= 1'b0;
			sclk_d_reg <= 1'b1;
			fall_reg <= 5'h1f;
			high_reg <= 8'h0;
			gap_reg <= 8'hff;
		end else begin
			convert_start_pin_d_reg <= convert_start_pin;
			sclk_d_reg <= sclk;
			if (convert_start_pin_d_reg && !convert_start_pin) begin
				fall_reg <= 5'h0;
			end else if (sclk_d_reg && !sclk && fall_reg != 5'h1f) begin
				fall_reg <= fall_reg + 5'h1;
			end
			high_reg <= !convert_start_pin ? 8'h0 : (high_reg == 8'hff ? high_reg : high_reg + 8'h1);
			gap_reg <= dout_oe ? 8'h0 : (gap_reg == 8'hff ? gap_reg : gap_reg + 8'h1);
		end
	end
	// falls so far, counting one that lands on this very edge
	assign falls = (convert_start_pin_d_reg && !convert_start_pin) ? 5'h0 : fall_reg + {4'h0, sclk_d_reg && !sclk};
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_enter_high; $fell(convert_start_pin) |-> sclk; endproperty
	a_enter_high: assert property (p_enter_high) else $error("select without clock high");
	property p_msb_on_select; $fell(convert_start_pin) |-> dout_oe; endproperty
	a_msb_on_select: assert property (p_msb_on_select) else $error("no output at select");
	property p_out_on_fall; dout_oe && $past(dout_oe) && sclk |-> $stable(dout); endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("output moved with clock high");
	property p_din_at_rise; $rose(sclk) && !convert_start_pin |-> $stable(din); endproperty
	a_din_at_rise: assert property (p_din_at_rise) else $error("input moved at rise");
	property p_release_last; falls == 5'd16 |-> !dout_oe; endproperty
	a_release_last: assert property (p_release_last) else $error("output held after last bit");
	property p_oe_in_frame; !convert_start_pin && falls < 5'd16 |-> dout_oe; endproperty
	a_oe_in_frame: assert property (p_oe_in_frame) else $error("output dropped in frame");
	property p_idle_clock; convert_start_pin |-> sclk; endproperty
	a_idle_clock: assert property (p_idle_clock) else $error("clock moved outside frame");
	property p_quiet_high; convert_start_pin && $past(convert_start_pin) |-> !dout_oe; endproperty
	a_quiet_high: assert property (p_quiet_high) else $error("output driven while start high");
	property p_conv_time; $fell(convert_start_pin) |-> high_reg >= 8'd75; endproperty
	a_conv_time: assert property (p_conv_time) else $error("read before conversion end");
	property p_acq_gap; $rose(convert_start_pin) |-> gap_reg >= 8'd25; endproperty
	a_acq_gap: assert property (p_acq_gap) else $error("acquisition gap too short");
	c_start: cover property ($rose(convert_start_pin));
	c_frame: cover property ($fell(convert_start_pin) ##1 dout_oe);
	c_last: cover property (fall_reg == 5'd16);
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
	import sar_link_pkg::*;
	localparam int GAP = 2000;
	logic clk, rst, ce, start, ready, data_valid;
	logic conv_busy, bandgap_on, ref_buffer_on, busy_b, bg_b, buf_b;
	logic [RESULT_W-1:0] sample_in, sample_b, data_out, conv_result, res_b;
	logic [CFG_W-1:0] cfg_in;
	ref_mode_type ref_mode, mode_b;
	int error_cnt, check_count, seed;
	sar_link_if lk();
	sar_link_if lb();
	sar_adc_host #(.MAX_GAP(GAP)) i_sar_adc_host (.clk(clk), .rst(rst), .ce(ce), .link(lk),
		.start(start), .cfg_in(cfg_in), .ready(ready), .data_out(data_out),
		.data_valid(data_valid));
	sar_adc_device i_sar_adc_device (.clk(clk), .rst(rst), .ce(ce), .link(lk),
		.sample_in(sample_in), .conv_busy(conv_busy), .conv_result(conv_result),
		.ref_mode(ref_mode), .bandgap_on(bandgap_on), .ref_buffer_on(ref_buffer_on));
	// second device driven by the bench in the host role
	sar_adc_device i_sar_adc_device_b (.clk(clk), .rst(rst), .ce(ce), .link(lb),
		.sample_in(sample_b), .conv_busy(busy_b), .conv_result(res_b),
		.ref_mode(mode_b), .bandgap_on(bg_b), .ref_buffer_on(buf_b));
	sar_link_checker i_sar_link_checker (.clk(clk), .rst(rst), .convert_start_pin(lk.convert_start_pin),
		.sclk(lk.sclk), .din(lk.din), .dout(lk.dout), .dout_oe(lk.dout_oe));
	////////////////////////////////////////////////////////////////
	always #10 clk = ~clk;
	// mode, bandgap, buffer expected for a mode code
	function automatic logic [3:0] ref_exp(input logic [1:0] m);
		return {m, ~m[0], ~m[1]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results;
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wait_valid(input int lim);
		for (int n = 0; data_valid !== 1'b1; n++) begin
			if (n > lim) begin
				error_cnt++;
				$display("Error data_valid expected 1 seen timeout");
				results();
			end
			@(negedge clk);
		end
	endtask
	// one host frame; input changed after sampling must not leak in
	task automatic host_frame(input logic [15:0] s, input logic [7:0] c);
		sample_in = s;
		cfg_in = c;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (9) @(negedge clk);
		chk("conv_busy", 16'h1, {15'h0, conv_busy});
		sample_in = ~s;
		wait_valid(400);
		chk("data_out", s, data_out);
		chk("conv_result", s, conv_result);
		chk("ready", 16'h0, {15'h0, ready});
		repeat (10) @(negedge clk);
		chk("ref", {12'h0, ref_exp(c[1:0])}, {12'h0, ref_mode, bandgap_on, ref_buffer_on});
		chk("data_valid", 16'h0, {15'h0, data_valid});
		repeat (20) @(negedge clk);
		chk("ready", 16'h1, {15'h0, ready});
	endtask
	// bench frame on the second device, entered with clock level ent
	task automatic bench_frame(input logic ent, input int n, input logic [15:0] w);
		logic [15:0] rd;
		rd = 16'h0;
		lb.convert_start_pin = 1'b1;
		repeat (10) @(negedge clk);
		chk("busy_b", 16'h1, {15'h0, busy_b});
		repeat (70) @(negedge clk);
		lb.sclk = ent;
		@(negedge clk);
		lb.convert_start_pin = 1'b0;
		// link clock of 125 ns, free of the system clock phase
		for (int i = 0; i < n; i++) begin
			#62.5;
			rd[15-i] = lb.dout;
			chk("dout_oe", {15'h0, ent}, {15'h0, lb.dout_oe});
			lb.sclk = 1'b0;
			lb.din = w[15-i];
			#62.5;
			lb.sclk = 1'b1;
		end
		repeat (4) @(negedge clk);
		lb.din = ~lb.din;
		if (ent && n == 16) begin
			chk("dout", sample_b, rd);
			chk("dout_oe", 16'h0, {15'h0, lb.dout_oe});
		end
		repeat (30) @(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog against a hang
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		$display("Error run expected end seen timeout");
		results();
	end
	initial begin
		seed = 32'hed31;
		error_cnt = 0;
		check_count = 0;
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		start = 1'b0;
		sample_in = 16'h0;
		cfg_in = 8'h0;
		sample_b = 16'ha5c3;
		lb.convert_start_pin = 1'b0;
		lb.sclk = 1'b1;
		lb.din = 1'b0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		chk("ref", 16'h3, {12'h0, ref_mode, bandgap_on, ref_buffer_on});
		host_frame(16'h0000, 8'h01);
		host_frame(16'hffff, 8'hfe);
		for (int i = 0; i < 8; i++) begin
			host_frame(16'($random(seed)), {6'($random(seed)), 2'(i)});
		end
		// start held high: back to back frames
		sample_in = 16'h8001;
		start = 1'b1;
		// clock enable low freezes both ends mid-conversion
		repeat (30) @(negedge clk);
		ce = 1'b0;
		repeat (10) @(negedge clk);
		ce = 1'b1;
		wait_valid(400);
		chk("data_out", 16'h8001, data_out);
		@(negedge clk);
		wait_valid(400);
		chk("data_out", 16'h8001, data_out);
		start = 1'b0;
		// long idle forces a conversion
		repeat (40) @(negedge clk);
		sample_in = 16'h1234;
		wait_valid(GAP + 400);
		chk("data_out", 16'h1234, data_out);
		bench_frame(1'b0, 16, 16'h0300);
		chk("mode_b", 16'h0, {14'h0, mode_b});
		bench_frame(1'b1, 8, 16'h0300);
		chk("mode_b", 16'h0, {14'h0, mode_b});
		bench_frame(1'b1, 16, 16'h0300);
		chk("mode_b", 16'h3, {14'h0, mode_b});
		chk("res_b", sample_b, res_b);
		chk("ref_b", {12'h0, ref_exp(2'h3)}, {12'h0, mode_b, bg_b, buf_b});
		results();
	end
endmodule
